// file: hdl/pms_sequencer.sv
// supply mode sequencer with lamps, apb registers and interrupt
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
// Overview of operation
// - battery with host drawing nothing enters sleep, peripherals off, controller asleep
// - in sleep only the real-time clock and an active shutdown window with its lamp run, all else stopped
// - sleep polls cable supply; cable present goes to cable mode, else battery
// - short button press in sleep powers the host, returns to battery
// - host socket mode only when host fed from own socket and allowed
// - header rail dip in a cable mode forces battery mode
// - after a rail dip battery mode holds at least the qualification time, unless an idle host sends it to sleep first
// - during a rail dip interval charging is suspended, all else runs
// - cable modes pulse activity lamp 100 ms every 500 ms with cable power
// - shutdown lamp dark, lit 800 ms per second during 40 s shutdown window
// - charging lamp lit in cable modes only while charging is in progress
// - in external mode usb lamp lit only with usb cable attached for data
// - in external mode usb draws no power and reads as disconnected
// - five supply states: usb, external, battery, sleep, host socket
// - external and usb both present selects external, usb path off
// - return from battery to cable only after cable stable for full 3.6 s; sleep goes to cable at its next poll
// - any cable instability during qualification restarts the timer from zero
module pms_sequencer #(
	parameter int unsigned TICK_CYC = pms_pkg::TICK_CYC
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_ext_present,
	input  wire logic        i_usb_present,
	input  wire logic        i_hostsock_present,
	input  wire logic        i_rail_low,
	input  wire logic        i_host_drawing,
	input  wire logic        i_charging,
	input  wire logic        i_shutdown_button,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             o_host_power_en,
	output logic             o_ext_path_en,
	output logic             o_usb_path_en,
	output logic             o_charge_en,
	output logic             o_periph_en,
	output logic             o_ctrl_sleep,
	output logic             o_rtc_en,
	output logic             o_activity_lamp,
	output logic             o_shutdown_lamp,
	output logic             o_charging_lamp,
	output logic             o_auxiliary_supply_lamp,
	output logic             o_usb_lamp,
	output logic             o_irq
);
	import pms_pkg::*;

	typedef struct packed {
		pms_state_t       state;
		logic [11:0]      qual;
		logic [9:0]       poll;
		logic [9:0]       idle;
		logic             peak;
		logic             sd_active;
		logic [15:0]      sd_ms;
		logic             btn_q;
		logic             hs_en;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_en;
		logic             irq;
		logic [31:0]      prdata;
		logic             pready;
		logic             pslverr;
		logic             host_pwr;
		logic             ext_path;
		logic             usb_path;
		logic             charge;
		logic             periph;
		logic             sleep;
		logic             rtc;
		logic             act_lamp;
		logic             sd_lamp;
		logic             chg_lamp;
		logic             aux_lamp;
		logic             usb_lamp;
	} pms_regs_t;

	pms_regs_t   r_reg;
	pms_regs_t   r_next;
	pms_tick_if  tk ();

	pms_timebase #(.TICK_CYC(TICK_CYC)) u_timebase (
		.i_core_clk (i_core_clk),
		.i_nrst     (i_nrst),
		.tb         (tk)
	);

	function automatic logic blink_on(input logic [9:0] ph, input int unsigned per,
			input int unsigned on);
		blink_on = (32'(ph) % per) < on;
	endfunction

	function automatic logic is_cable(input pms_state_t s);
		is_cable = (s == USB_CABLE_STATE) || (s == EXTERNAL_SUPPLY_STATE) ||
			(s == HOST_SOCKET_SUPPLY_STATE);
	endfunction

	logic       cable_ok;
	logic       btn_rise;
	logic       acc;
	logic       wr;
	logic       unmapped;
	logic       sd_start;
	logic [IRQ_W-1:0] irq_ev;
	logic [IRQ_W-1:0] irq_clr;
	pms_state_t pref;
	logic [31:0] status_word;

	always_comb begin
		cable_ok = i_ext_present || i_usb_present || (i_hostsock_present && r_reg.hs_en);
		// external beats usb, usb beats the host socket
		if (i_ext_present) begin
			pref = EXTERNAL_SUPPLY_STATE;
		end else if (i_usb_present) begin
			pref = USB_CABLE_STATE;
		end else begin
			pref = HOST_SOCKET_SUPPLY_STATE;
		end
		btn_rise = i_shutdown_button && !r_reg.btn_q;
		acc      = psel && penable && r_reg.pready;
		wr       = acc && pwrite;
		unmapped = !(paddr == OFF_CTRL || paddr == OFF_STATUS || paddr == OFF_IRQ_STAT ||
			paddr == OFF_IRQ_EN || paddr == OFF_IRQ_CLR);
		sd_start = wr && (paddr == OFF_CTRL) && pwdata[CTRL_SD_START];
		irq_clr  = (wr && paddr == OFF_IRQ_CLR) ? pwdata[IRQ_W-1:0] : '0;
		// usb reads as disconnected while external feeds the board
		status_word = '0;
		status_word[2:0] = r_reg.state;
		status_word[ST_PEAK_BIT] = r_reg.peak;
		status_word[ST_SD_BIT] = r_reg.sd_active;
		status_word[ST_USB_BIT] = (r_reg.state == USB_CABLE_STATE);
		status_word[ST_EXT_BIT] = (r_reg.state == EXTERNAL_SUPPLY_STATE);
	end

	always_comb begin
		r_next       = r_reg;
		r_next.btn_q = i_shutdown_button;
		irq_ev       = '0;
		unique case (r_reg.state)
			USB_CABLE_STATE, EXTERNAL_SUPPLY_STATE, HOST_SOCKET_SUPPLY_STATE: begin
				r_next.qual = 12'h000;
				if (i_rail_low) begin
					r_next.state = STORED_ENERGY_STATE;
					r_next.peak  = 1'b1;
				end else if (!cable_ok) begin
					r_next.state = STORED_ENERGY_STATE;
				end else if (r_reg.state != pref) begin
					r_next.state = pref;
				end
			end
			STORED_ENERGY_STATE: begin
				if (!cable_ok || i_rail_low) begin
					r_next.qual = 12'h000;
				end else if (tk.tick) begin
					if (r_reg.qual == QUAL_LAST) begin
						r_next.state = pref;
						r_next.qual  = 12'h000;
						r_next.peak  = 1'b0;
					end else begin
						r_next.qual = r_reg.qual + 12'h001;
					end
				end
				// a host just powered needs time to start drawing before we sleep
				if (i_host_drawing) begin
					r_next.idle = 10'h000;
				end else if (tk.tick) begin
					if (r_reg.idle == IDLE_LAST) begin
						r_next.state = SLEEP_SUPPLY_STATE;
						r_next.idle  = 10'h000;
						r_next.qual  = 12'h000;
						r_next.peak  = 1'b0;
					end else begin
						r_next.idle = r_reg.idle + 10'h001;
					end
				end
			end
			SLEEP_SUPPLY_STATE: begin
				if (btn_rise) begin
					r_next.state = STORED_ENERGY_STATE;
					r_next.poll  = 10'h000;
					irq_ev[IRQ_BUTTON] = 1'b1;
				end else if (tk.tick) begin
					if (r_reg.poll == POLL_LAST) begin
						r_next.poll  = 10'h000;
						r_next.state = cable_ok ? pref : STORED_ENERGY_STATE;
					end else begin
						r_next.poll = r_reg.poll + 10'h001;
					end
				end
			end
		endcase
		irq_ev[IRQ_STATE] = (r_next.state != r_reg.state);

		// safe-shutdown window, restarted by a fresh request
		if (sd_start) begin
			r_next.sd_active = 1'b1;
			r_next.sd_ms     = 16'h0000;
		end else if (r_reg.sd_active && tk.tick) begin
			if (r_reg.sd_ms == SD_LAST) begin
				r_next.sd_active = 1'b0;
				irq_ev[IRQ_SD_DONE] = 1'b1;
			end else begin
				r_next.sd_ms = r_reg.sd_ms + 16'h0001;
			end
		end

		// supply outputs follow the state being entered so they match it in the same cycle; lamps follow the current state, one cycle later
		r_next.host_pwr = (r_next.state != SLEEP_SUPPLY_STATE);
		r_next.ext_path = (r_next.state == EXTERNAL_SUPPLY_STATE);
		r_next.usb_path = (r_next.state == USB_CABLE_STATE);
		r_next.charge   = is_cable(r_next.state) && !r_next.peak;
		r_next.periph   = (r_next.state != SLEEP_SUPPLY_STATE);
		r_next.sleep    = (r_next.state == SLEEP_SUPPLY_STATE);
		r_next.rtc      = 1'b1;
		r_next.act_lamp = is_cable(r_reg.state) && cable_ok &&
			blink_on(tk.phase, ACT_PERIOD_MS, ACT_ON_MS);
		r_next.sd_lamp  = r_reg.sd_active &&
			blink_on(tk.phase, SD_PERIOD_MS, SD_ON_MS);
		r_next.chg_lamp = is_cable(r_reg.state) && i_charging;
		r_next.aux_lamp = (r_reg.state == EXTERNAL_SUPPLY_STATE);
		r_next.usb_lamp = (r_reg.state == USB_CABLE_STATE) ||
			((r_reg.state == EXTERNAL_SUPPLY_STATE) && i_usb_present);

		// set wins over a clear in the same cycle
		r_next.irq_stat = (r_reg.irq_stat & ~irq_clr) | irq_ev;
		if (wr && paddr == OFF_IRQ_EN) begin
			r_next.irq_en = pwdata[IRQ_W-1:0];
		end
		if (wr && paddr == OFF_CTRL) begin
			r_next.hs_en = pwdata[CTRL_HS_EN];
		end
		r_next.irq = |(r_next.irq_stat & r_next.irq_en);

		// apb: one wait-free access phase after each setup cycle
		r_next.pready  = psel && !penable;
		r_next.pslverr = psel && !penable && unmapped;
		r_next.prdata  = 32'h0000_0000;
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
				OFF_CTRL:     r_next.prdata = 32'(r_reg.hs_en) << CTRL_HS_EN;
				OFF_STATUS:   r_next.prdata = status_word;
				OFF_IRQ_STAT: r_next.prdata = 32'(r_reg.irq_stat);
				OFF_IRQ_EN:   r_next.prdata = 32'(r_reg.irq_en);
				default:      r_next.prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			r_reg          <= '0;
			r_reg.state    <= STORED_ENERGY_STATE;
			r_reg.irq_en   <= IRQ_EN_RST;
			r_reg.host_pwr <= 1'b1;
			r_reg.periph   <= 1'b1;
			r_reg.rtc      <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign prdata                  = r_reg.prdata;
	assign pready                  = r_reg.pready;
	assign pslverr                 = r_reg.pslverr;
	assign o_host_power_en         = r_reg.host_pwr;
	assign o_ext_path_en           = r_reg.ext_path;
	assign o_usb_path_en           = r_reg.usb_path;
	assign o_charge_en             = r_reg.charge;
	assign o_periph_en             = r_reg.periph;
	assign o_ctrl_sleep            = r_reg.sleep;
	assign o_rtc_en                = r_reg.rtc;
	assign o_activity_lamp         = r_reg.act_lamp;
	assign o_shutdown_lamp         = r_reg.sd_lamp;
	assign o_charging_lamp         = r_reg.chg_lamp;
	assign o_auxiliary_supply_lamp = r_reg.aux_lamp;
	assign o_usb_lamp              = r_reg.usb_lamp;
	assign o_irq                   = r_reg.irq;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);

	sequence s_cable_dip;
		is_cable(r_reg.state) && i_rail_low;
	endsequence
	sequence s_qual_done;
		r_reg.state == STORED_ENERGY_STATE ##1 is_cable(r_reg.state);
	endsequence
	sequence s_sleep_press;
		r_reg.state == SLEEP_SUPPLY_STATE && btn_rise;
	endsequence

	a_peak_to_bat: assert property (s_cable_dip |=> r_reg.state == STORED_ENERGY_STATE && r_reg.peak && !o_charge_en) else $error("rail dip did not force battery");
	a_qual_full: assert property (s_qual_done |-> $past(r_reg.qual) == QUAL_LAST && $past(tk.tick)) else $error("cable return before qualification");
	a_qual_restart: assert property (r_reg.state == STORED_ENERGY_STATE && !cable_ok |=> r_reg.qual == 12'h000) else $error("qualification not restarted");
	a_ext_priority: assert property (r_reg.state == USB_CABLE_STATE && i_ext_present && !i_rail_low |=> r_reg.state == EXTERNAL_SUPPLY_STATE ##1 !o_usb_path_en) else $error("external did not take priority");
	a_sleep_quiet: assert property (r_reg.state == SLEEP_SUPPLY_STATE |-> !o_periph_en && o_ctrl_sleep && o_rtc_en && !o_host_power_en) else $error("peripherals awake in sleep");
	a_button_wake: assert property (s_sleep_press |=> r_reg.state == STORED_ENERGY_STATE && o_host_power_en && r_reg.irq_stat[IRQ_BUTTON]) else $error("button did not wake host");
	a_act_lamp: assert property (o_activity_lamp |-> $past(is_cable(r_reg.state)) && $past(tk.phase) % 10'd500 < 10'd100) else $error("activity lamp out of pattern");
	a_sd_lamp: assert property (!r_reg.sd_active ##1 !r_reg.sd_active |-> !o_shutdown_lamp) else $error("shutdown lamp lit outside window");
	a_chg_lamp: assert property (o_charging_lamp |-> $past(i_charging)) else $error("charging lamp without charging");
	a_ext_usb_rep: assert property (r_reg.state == EXTERNAL_SUPPLY_STATE && psel && !penable && !pwrite && paddr == OFF_STATUS |=> !prdata[ST_USB_BIT]) else $error("usb reported connected in external mode");
	a_idle_sleep: assert property (r_reg.state == STORED_ENERGY_STATE && !i_host_drawing && tk.tick && r_reg.idle == IDLE_LAST && !(cable_ok && !i_rail_low && r_reg.qual == QUAL_LAST) |=> r_reg.state == SLEEP_SUPPLY_STATE) else $error("no sleep when host idle");
endmodule

// file: hdl/pms_pkg.sv
// constants and types shared by the supply sequencer
package pms_pkg;
	localparam int unsigned CLK_HZ        = 50_000_000;
	localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
	localparam int unsigned MS_NS         = 1_000_000;
	localparam int unsigned TICK_CYC      = MS_NS / CLK_PERIOD_NS;

	localparam int unsigned QUAL_MS       = 3600;
	localparam int unsigned ACT_PERIOD_MS = 500;
	localparam int unsigned ACT_ON_MS     = 100;
	localparam int unsigned SD_PERIOD_MS  = 1000;
	localparam int unsigned SD_ON_MS      = 800;
	localparam int unsigned SD_WIN_MS     = 40000;
	localparam int unsigned POLL_MS       = 1000;
	localparam int unsigned IDLE_MS       = 500;

	localparam logic [11:0] QUAL_LAST = 12'(QUAL_MS - 1);
	localparam logic [15:0] SD_LAST   = 16'(SD_WIN_MS - 1);
	localparam logic [9:0]  POLL_LAST = 10'(POLL_MS - 1);
	localparam logic [9:0]  IDLE_LAST = 10'(IDLE_MS - 1);
	localparam logic [9:0]  PHASE_LAST = 10'(SD_PERIOD_MS - 1);

	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_STATUS   = 8'h04;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFF_IRQ_EN   = 8'h0c;
	localparam logic [7:0] OFF_IRQ_CLR  = 8'h10;

	localparam int unsigned CTRL_SD_START = 0;
	localparam int unsigned CTRL_HS_EN    = 1;
	localparam int unsigned ST_PEAK_BIT   = 3;
	localparam int unsigned ST_SD_BIT     = 4;
	localparam int unsigned ST_USB_BIT    = 5;
	localparam int unsigned ST_EXT_BIT    = 6;
	localparam int unsigned IRQ_W         = 3;
	localparam int unsigned IRQ_STATE     = 0;
	localparam int unsigned IRQ_BUTTON    = 1;
	localparam int unsigned IRQ_SD_DONE   = 2;
	localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;

	typedef enum logic [2:0] {
		USB_CABLE_STATE,
		EXTERNAL_SUPPLY_STATE,
		STORED_ENERGY_STATE,
		SLEEP_SUPPLY_STATE,
		HOST_SOCKET_SUPPLY_STATE
	} pms_state_t;
endpackage

// file: hdl/pms_tick_if.sv
// common millisecond tick and frame phase
`timescale 1ns/100ps
interface pms_tick_if;
	logic       tick;
	logic [9:0] phase;
	modport src (output tick, output phase);
	modport dst (input tick, input phase);
endinterface

// file: hdl/pms_timebase.sv
// millisecond tick divider and one-second phase counter
`timescale 1ns/100ps
module pms_timebase #(
	parameter int unsigned TICK_CYC = pms_pkg::TICK_CYC
) (
	input  wire logic  i_core_clk,
	input  wire logic  i_nrst,
	pms_tick_if.src    tb
);
	import pms_pkg::*;

	typedef struct packed {
		logic [15:0] div;
		logic        tick;
		logic [9:0]  phase;
	} pms_tb_t;

	pms_tb_t tb_reg;
	pms_tb_t tb_next;

	always_comb begin
		tb_next      = tb_reg;
		tb_next.tick = 1'b0;
		if (tb_reg.div == 16'(TICK_CYC - 1)) begin
			tb_next.div  = 16'h0000;
			tb_next.tick = 1'b1;
		end else begin
			tb_next.div = tb_reg.div + 16'h0001;
		end
		if (tb_reg.tick) begin
			tb_next.phase = (tb_reg.phase == PHASE_LAST) ? 10'h000 : tb_reg.phase + 10'h001;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			tb_reg <= '0;
		end else begin
			tb_reg <= tb_next;
		end
	end

	assign tb.tick  = tb_reg.tick;
	assign tb.phase = tb_reg.phase;
endmodule

// file: tb/pms_host_model.sv
// host computer model fed through the header rail
`timescale 1ns/100ps
module pms_host_model #(
	parameter int unsigned PEAK_CYC = 3
) (
	input  wire logic i_core_clk,
	input  wire logic i_host_power_en,
	input  wire logic i_idle,
	input  wire logic i_peak,
	output logic      o_host_drawing,
	output logic      o_rail_low
);
	int unsigned left = 0;
	// host draws only while powered and busy
	assign o_host_drawing = i_host_power_en & ~i_idle;
	// a current peak drags the rail down briefly, then the load eases
	always @(posedge i_core_clk) begin
		if (i_peak && i_host_power_en) begin
			left <= PEAK_CYC;
		end else if (left != 0) begin
			left <= left - 1;
		end
	end
	assign o_rail_low = (left != 0);
endmodule

// file: tb/tb_top.sv
// self-checking bench for the supply mode sequencer
`timescale 1ns/100ps
module tb_top;
	import pms_pkg::*;
	// short tick keeps the 3.6 s qualification within a sane run length
	localparam int unsigned TC = 2;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        auxiliary_supply_lamp = 1'b0;
	logic        usb = 1'b0;
	logic        hs = 1'b0;
	logic        charging_lamp = 1'b0;
	logic        btn = 1'b0;
	logic        idle = 1'b0;
	logic        peak = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rdat;
	logic        pready, pslverr, rerr, drawing, rail_low;
	logic        host_pwr, ext_path, usb_path, chg_en, periph, sleep, rtc;
	logic        act_l, sd_l, chg_l, aux_l, usb_l, irq;
	int          num_errors = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          cnt;

	always #10 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	pms_sequencer #(.TICK_CYC(TC)) DUT (
		.i_core_clk(clk), .i_nrst(nrst), .i_ext_present(auxiliary_supply_lamp), .i_usb_present(usb),
		.i_hostsock_present(hs), .i_rail_low(rail_low), .i_host_drawing(drawing),
		.i_charging(charging_lamp), .i_shutdown_button(btn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .o_host_power_en(host_pwr),
		.o_ext_path_en(ext_path), .o_usb_path_en(usb_path), .o_charge_en(chg_en),
		.o_periph_en(periph), .o_ctrl_sleep(sleep), .o_rtc_en(rtc),
		.o_activity_lamp(act_l), .o_shutdown_lamp(sd_l), .o_charging_lamp(chg_l),
		.o_auxiliary_supply_lamp(aux_l), .o_usb_lamp(usb_l), .o_irq(irq));

	pms_host_model HOST (
		.i_core_clk(clk), .i_host_power_en(host_pwr), .i_idle(idle), .i_peak(peak),
		.o_host_drawing(drawing), .o_rail_low(rail_low));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic wait_c(input int n);
		repeat (n) @(posedge clk);
	endtask

	// request held until pready is seen high at a rising edge; only the watchdog ends a wait
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	// polls the state code, bounded by t ticks
	task automatic wait_st(input logic [2:0] c, input int t);
		int lim;
		lim = cyc + t * TC;
		do rd(OFF_STATUS);
		while (rdat[2:0] !== c && cyc < lim);
	endtask

	task automatic cnt_lamp(input logic sd, input int n);
		cnt = 0;
		repeat (n) begin
			@(posedge clk);
			cnt += int'(sd ? sd_l : act_l);
		end
	endtask

	task automatic t_reset;
		check({host_pwr, periph, rtc, sleep}, 4'he);
		rd(OFF_STATUS);
		check(rdat, 32'(STORED_ENERGY_STATE));
		rd(8'h20);
		check(rerr, 1'b1);
		check(rdat, 32'h0);
		rd(OFF_IRQ_EN);
		check(rdat, 32'h0);
	endtask

	task automatic t_usb;
		usb <= 1'b1;
		wait_c(2000 * TC);
		usb <= 1'b0;
		@(posedge clk);
		usb <= 1'b1;
		wait_c(3000 * TC);
		rd(OFF_STATUS);
		check(rdat[2:0], STORED_ENERGY_STATE);
		wait_st(USB_CABLE_STATE, 800);
		check(rdat[2:0], USB_CABLE_STATE);
		check({usb_path, ext_path, chg_en}, 3'h5);
		charging_lamp <= 1'b1;
		wait_c(4);
		check(chg_l, 1'b1);
		charging_lamp <= 1'b0;
		wait_c(4);
		check(chg_l, 1'b0);
		cnt_lamp(1'b0, 500 * TC);
		check(cnt, 100 * TC);
	endtask

	task automatic t_peak;
		wr(OFF_IRQ_EN, 32'h1);
		wr(OFF_IRQ_CLR, 32'h7);
		peak <= 1'b1;
		@(posedge clk);
		peak <= 1'b0;
		wait_c(5);
		check({usb_path, chg_en, periph, host_pwr, irq}, 5'h07);
		rd(OFF_STATUS);
		check(rdat[3:0], 4'ha);
		wr(OFF_IRQ_CLR, 32'h1);
		wait_c(2);
		check(irq, 1'b0);
		wait_c(3500 * TC);
		rd(OFF_STATUS);
		check(rdat[2:0], STORED_ENERGY_STATE);
		wait_st(USB_CABLE_STATE, 300);
		check(rdat[3:0], 4'h0);
	endtask

	task automatic t_ext;
		wr(OFF_IRQ_EN, 32'h0);
		// irq register takes the new enable at the write edge, seen one edge later
		wait_c(1);
		check(irq, 1'b0);
		auxiliary_supply_lamp <= 1'b1;
		wait_st(EXTERNAL_SUPPLY_STATE, 3700);
		check(rdat[6:0], 7'h41);
		wait_c(2);
		check({ext_path, usb_path, aux_l, usb_l}, 4'hb);
		usb <= 1'b0;
		wait_c(4);
		check(usb_l, 1'b0);
	endtask

	task automatic t_sd;
		check(sd_l, 1'b0);
		wr(OFF_CTRL, 32'h1);
		rd(OFF_STATUS);
		check(rdat[4], 1'b1);
		cnt_lamp(1'b1, 1000 * TC);
		check(cnt, 800 * TC);
		rd(OFF_CTRL);
		check(rdat, 32'h0);
	endtask

	task automatic t_sleep;
		wr(OFF_IRQ_EN, 32'h2);
		auxiliary_supply_lamp <= 1'b0;
		idle <= 1'b1;
		wait_st(SLEEP_SUPPLY_STATE, 700);
		check(rdat[2:0], SLEEP_SUPPLY_STATE);
		check({sleep, periph, host_pwr, rtc, chg_en}, 5'h12);
		btn <= 1'b1;
		wait_c(2);
		btn <= 1'b0;
		wait_c(2);
		check({host_pwr, irq}, 2'h3);
		rd(OFF_STATUS);
		check(rdat[2:0], STORED_ENERGY_STATE);
		wait_st(SLEEP_SUPPLY_STATE, 700);
		usb <= 1'b1;
		wait_st(USB_CABLE_STATE, 1100);
		check(rdat[2:0], USB_CABLE_STATE);
	endtask

	task automatic t_hs;
		idle <= 1'b0;
		usb <= 1'b0;
		hs <= 1'b1;
		wait_c(3700 * TC);
		rd(OFF_STATUS);
		check(rdat[2:0], STORED_ENERGY_STATE);
		wr(OFF_CTRL, 32'h2);
		wait_st(HOST_SOCKET_SUPPLY_STATE, 3700);
		check(rdat[2:0], HOST_SOCKET_SUPPLY_STATE);
		check(usb_path | ext_path, 1'b0);
	endtask

	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_reset();
		t_usb();
		t_peak();
		t_ext();
		t_sd();
		t_sleep();
		t_hs();
		test_done();
	end

	// about twice the expected run length, kept under the cycle budget
	initial begin
		repeat (90000) @(posedge clk);
		num_errors++;
		test_done();
	end
endmodule
